// ==== rtl/emsq_pkg.sv ====
`default_nettype none
package emsq_pkg;
   // Register byte addresses on the APB slave
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_LINE   = 8'h04;
   localparam logic [7:0] ADDR_FRAME  = 8'h08;
   localparam logic [7:0] ADDR_COARSE = 8'h0c;
   localparam logic [7:0] ADDR_FINE   = 8'h10;
   localparam logic [7:0] ADDR_OFFSET = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;

   // Control word fields
   localparam int CTRL_EN_BIT   = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam int CTRL_POL_BIT  = 3;

   // Status word fields
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_MODE_LSB  = 4;
   localparam int STAT_RD_BIT    = 6;
   localparam int STAT_PEND_BIT  = 7;
   localparam int STAT_CNT_LSB   = 16;

   typedef enum logic [1:0] {
      EMSQ_FREE,
      EMSQ_TRIG,
      EMSQ_SLAVE,
      EMSQ_BAD
   } emsq_mode_t;

   typedef struct packed {
      logic        en;
      emsq_mode_t  mode;
      logic        pol;
      logic [15:0] line_time;
      logic [15:0] frame_length;
      logic [15:0] coarse;
      logic [15:0] fine;
      logic [15:0] offset;
   } emsq_cfg_t;

   // Reset values
   localparam logic [15:0] RST_LINE_TIME = 16'h0100;
   localparam logic [15:0] RST_FRAME_LEN = 16'h1000;
   localparam logic [15:0] RST_COARSE    = 16'h0100;
   localparam logic [15:0] RST_FINE      = 16'h0000;
   localparam logic [15:0] RST_OFFSET    = 16'h0000;

   // Sequencer timing
   localparam logic [31:0] START_EXPOSURE_OVERHEAD_CYC      = 32'h0000_0040;
   localparam logic [31:0] END_EXPOSURE_OVERHEAD_CYC      = 32'h0000_0080;
   localparam logic [15:0] OFS_OVH_LINES = 16'h0002;
   localparam logic [15:0] READ_ROWS     = 16'h0c10;
endpackage : emsq_pkg
`default_nettype wire

// ==== rtl/emsq_sequencer.sv ====
// How it works
// - Free mode exposes and reads frames repeatedly from register settings.
// - Frame is non-exposing time plus exposure, counted in whole lines.
// - Exposure opens with start overhead, closes with end overhead sampling.
// - Row readout pauses while either overhead sequence runs.
// - Line period is in clock cycles; software keeps it above conversion.
// - Frame time equals frame span times line period.
// - Exposure cycles are coarse count times line period plus fine.
// - Delay before start overhead is (coarse delay + overhead) lines.
// - Triggered master: each active trigger edge starts an exposure; the code keeps one edge while busy and drops later ones.
// - Triggered master: expose coarse plus fine, end overhead, readout.
// - Triggered master: inactive trigger edge has no effect.
// - One image per trigger; trigger during readout pipelines exposure.
// - Trigger to start overhead latency is constant, set by delay.
// - Trigger pin passes a two-stage synchroniser before use.
// - Polarity bit selects active level; zero means rising edge start.
// - Triggered master ignores frame span.
// - Slave mode ignores frame span and exposure counts.
// - Slave: pin asserted starts exposure, deassertion samples and reads.
// - Slave: fixed latencies; assertion delay follows coarse delay.
//
// Design decisions made here: the APB slave port and the address map.
`default_nettype none
module emsq_sequencer (
   input  wire logic        REF_CLK,
   input  wire logic        RST,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output var  logic [31:0] PRDATA,
   output var  logic        PREADY,
   output var  logic        PSLVERR,
   input  wire logic        TRIG_EXPOSE,
   output var  logic        EXPOSING,
   output var  logic        START_OVERHEAD,
   output var  logic        END_OVERHEAD,
   output var  logic        READOUT_ACTIVE,
   output var  logic        ROW_STROBE,
   output var  logic        FRAME_DONE
);
   typedef enum logic [2:0] {
      S_IDLE,
      S_DELAY,
      S_START_EXPOSURE_OVERHEAD,
      S_EXPOSE,
      S_END_EXPOSURE_OVERHEAD
   } emsq_state_t;

   emsq_pkg::emsq_cfg_t  cfg;
   emsq_pkg::emsq_mode_t mode_q;
   emsq_state_t          state;
   emsq_state_t          next_state;

   logic        sync1;
   logic        sync2;
   logic        sync3;
   logic [31:0] cnt;
   logic [31:0] frame_cnt;
   logic        pend;
   logic        rd_busy;
   logic [15:0] rd_row;
   logic [15:0] rd_cyc;
   logic [15:0] img_cnt;

   // APB decode
   wire acc      = PSEL & PENABLE & ~PREADY;
   wire wr_en    = PSEL & PENABLE & PREADY & PWRITE;
   wire hit_ctrl = PADDR == emsq_pkg::ADDR_CTRL;
   wire hit_line = PADDR == emsq_pkg::ADDR_LINE;
   wire hit_frm  = PADDR == emsq_pkg::ADDR_FRAME;
   wire hit_crs  = PADDR == emsq_pkg::ADDR_COARSE;
   wire hit_fine = PADDR == emsq_pkg::ADDR_FINE;
   wire hit_ofs  = PADDR == emsq_pkg::ADDR_OFFSET;
   wire hit_stat = PADDR == emsq_pkg::ADDR_STATUS;
   wire mapped   = hit_ctrl | hit_line | hit_frm | hit_crs | hit_fine
                   | hit_ofs | hit_stat;
   wire [1:0] wr_mode = PWDATA[emsq_pkg::CTRL_MODE_LSB +: 2];
   wire mode_ok  = wr_mode != 2'(emsq_pkg::EMSQ_BAD);

   wire [31:0] ctrl_word = {28'h0, cfg.pol, cfg.mode, cfg.en};
   wire [31:0] stat_word = {img_cnt, 8'h0, pend, rd_busy, mode_q,
                            1'b0, state};
   wire [31:0] rd_mux =
      hit_ctrl ? ctrl_word :
      hit_line ? {16'h0, cfg.line_time} :
      hit_frm  ? {16'h0, cfg.frame_length} :
      hit_crs  ? {16'h0, cfg.coarse} :
      hit_fine ? {16'h0, cfg.fine} :
      hit_ofs  ? {16'h0, cfg.offset} :
      hit_stat ? stat_word : 32'h0;

   // One wait state on every access
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         PREADY  <= 1'b0;
         PRDATA  <= 32'h0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= acc;
         PRDATA  <= (acc & ~PWRITE) ? rd_mux : 32'h0;
         PSLVERR <= acc & ~mapped;
      end
   end

   // Reserved mode code is refused, the old mode stays
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         cfg.en           <= 1'b0;
         cfg.mode         <= emsq_pkg::EMSQ_FREE;
         cfg.pol          <= 1'b0;
         cfg.line_time    <= emsq_pkg::RST_LINE_TIME;
         cfg.frame_length <= emsq_pkg::RST_FRAME_LEN;
         cfg.coarse       <= emsq_pkg::RST_COARSE;
         cfg.fine         <= emsq_pkg::RST_FINE;
         cfg.offset       <= emsq_pkg::RST_OFFSET;
      end else if (wr_en) begin
         if (hit_ctrl) begin
            cfg.en  <= PWDATA[emsq_pkg::CTRL_EN_BIT];
            cfg.pol <= PWDATA[emsq_pkg::CTRL_POL_BIT];
            if (mode_ok) begin
               cfg.mode <= emsq_pkg::emsq_mode_t'(wr_mode);
            end
         end
         if (hit_line) begin
            cfg.line_time <= PWDATA[15:0];
         end
         if (hit_frm) begin
            cfg.frame_length <= PWDATA[15:0];
         end
         if (hit_crs) begin
            cfg.coarse <= PWDATA[15:0];
         end
         if (hit_fine) begin
            cfg.fine <= PWDATA[15:0];
         end
         if (hit_ofs) begin
            cfg.offset <= PWDATA[15:0];
         end
      end
   end

   // Trigger synchroniser; sync1 feeds only sync2
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         sync3 <= 1'b0;
      end else begin
         sync1 <= TRIG_EXPOSE;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   wire trig_lvl  = sync2 ^ cfg.pol;
   wire trig_prev = sync3 ^ cfg.pol;
   wire trig_edge = trig_lvl & ~trig_prev;

   // Timing targets
   wire [31:0] line32    = {16'h0, cfg.line_time};
   // Operands widened first, a bare 16x16 product would wrap at 16 bits
   wire [31:0] frame_tgt = 32'(cfg.frame_length)
                           * 32'(cfg.line_time);
   wire [32:0] exp_sum   = 33'(32'(cfg.coarse) * 32'(cfg.line_time))
                           + 33'(cfg.fine);
   wire [31:0] exp_tgt   = exp_sum[31:0];
   wire [16:0] ofs_lines = 17'(cfg.offset) + 17'(emsq_pkg::OFS_OVH_LINES);
   wire [31:0] dly_tgt   = 32'(ofs_lines) * 32'(cfg.line_time);
   wire [31:0] cnt_inc   = cnt + 32'h1;

   wire frame_tick = cnt_hit(frame_cnt, frame_tgt);
   wire dly_done   = cnt_hit(cnt, dly_tgt);
   wire start_exposure_overhead_done  = cnt_inc >= emsq_pkg::START_EXPOSURE_OVERHEAD_CYC;
   wire end_exposure_overhead_done  = cnt_inc >= emsq_pkg::END_EXPOSURE_OVERHEAD_CYC;
   wire exp_done   = (mode_q == emsq_pkg::EMSQ_SLAVE) ? ~trig_lvl
                     : cnt_hit(cnt, exp_tgt);

   function automatic logic cnt_hit(input logic [31:0] c,
                                    input logic [31:0] t);
      cnt_hit = (c + 32'h1) >= t;
   endfunction : cnt_hit

   // Start conditions per mode
   wire idle      = state == S_IDLE;
   wire boundary  = idle & ~rd_busy;
   wire start_fr  = cfg.en & (mode_q == emsq_pkg::EMSQ_FREE)
                    & frame_tick;
   wire start_tr  = cfg.en & (mode_q == emsq_pkg::EMSQ_TRIG)
                    & (trig_edge | pend);
   wire start_sl  = cfg.en & (mode_q == emsq_pkg::EMSQ_SLAVE)
                    & trig_lvl & ~trig_prev;
   wire start_exp = idle & (start_fr | start_tr | start_sl);
   wire rd_start  = (state == S_END_EXPOSURE_OVERHEAD) & end_exposure_overhead_done;
   wire overhead  = (state == S_START_EXPOSURE_OVERHEAD) | (state == S_END_EXPOSURE_OVERHEAD);

   // Free-running frame timer; ignored in trigger modes
   always_ff @(posedge REF_CLK) begin
      if (RST || mode_q != emsq_pkg::EMSQ_FREE || !cfg.en) begin
         frame_cnt <= 32'h0;
      end else if (frame_tick) begin
         frame_cnt <= 32'h0;
      end else begin
         frame_cnt <= frame_cnt + 32'h1;
      end
   end

   // Mode is only taken over when nothing is in flight
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         mode_q <= emsq_pkg::EMSQ_FREE;
      end else if (boundary) begin
         mode_q <= cfg.mode;
      end
   end

   // One trigger kept while busy; further edges before it is served give no image
   always_ff @(posedge REF_CLK) begin
      if (RST || mode_q != emsq_pkg::EMSQ_TRIG) begin
         pend <= 1'b0;
      end else if (trig_edge && !idle) begin
         pend <= 1'b1;
      end else if (idle) begin
         pend <= 1'b0;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         S_IDLE: begin
            if (start_exp) begin
               next_state = S_DELAY;
            end
         end
         S_DELAY: begin
            if (dly_done) begin
               next_state = S_START_EXPOSURE_OVERHEAD;
            end
         end
         S_START_EXPOSURE_OVERHEAD: begin
            if (start_exposure_overhead_done) begin
               next_state = S_EXPOSE;
            end
         end
         S_EXPOSE: begin
            if (exp_done) begin
               next_state = S_END_EXPOSURE_OVERHEAD;
            end
         end
         S_END_EXPOSURE_OVERHEAD: begin
            if (end_exposure_overhead_done) begin
               next_state = S_IDLE;
            end
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         state <= S_IDLE;
         cnt   <= 32'h0;
      end else begin
         state <= next_state;
         cnt   <= (next_state != state) ? 32'h0 : cnt_inc;
      end
   end

   // Row readout, held during overhead sequences
   wire row_end  = (rd_cyc + 16'h1) >= cfg.line_time;
   wire last_row = (rd_row + 16'h1) >= emsq_pkg::READ_ROWS;

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         rd_busy <= 1'b0;
         rd_row  <= 16'h0;
         rd_cyc  <= 16'h0;
      end else if (rd_start) begin
         rd_busy <= 1'b1;
         rd_row  <= 16'h0;
         rd_cyc  <= 16'h0;
      end else if (rd_busy && !overhead) begin
         rd_cyc <= row_end ? 16'h0 : rd_cyc + 16'h1;
         if (row_end) begin
            rd_row  <= rd_row + 16'h1;
            rd_busy <= ~last_row;
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         EXPOSING       <= 1'b0;
         START_OVERHEAD <= 1'b0;
         END_OVERHEAD   <= 1'b0;
         READOUT_ACTIVE <= 1'b0;
         ROW_STROBE     <= 1'b0;
         FRAME_DONE     <= 1'b0;
         img_cnt        <= 16'h0;
      end else begin
         EXPOSING       <= state == S_EXPOSE;
         START_OVERHEAD <= state == S_START_EXPOSURE_OVERHEAD;
         END_OVERHEAD   <= state == S_END_EXPOSURE_OVERHEAD;
         READOUT_ACTIVE <= rd_busy & ~overhead;
         ROW_STROBE     <= rd_busy & ~overhead & row_end;
         FRAME_DONE     <= rd_busy & ~overhead & row_end & last_row;
         if (rd_busy && !overhead && row_end && last_row) begin
            img_cnt <= img_cnt + 16'h1;
         end
      end
   end

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);

   AST_NO_ROWS_IN_OVERHEAD: assert property (
      overhead && !rd_start
      |=> $stable(rd_cyc) && $stable(rd_row) && !READOUT_ACTIVE)
      else $error("readout advanced during overhead");

   AST_DELAY_TO_START_EXPOSURE_OVERHEAD: assert property (
      state == S_DELAY && cnt + 32'h1 >= dly_tgt |=> state == S_START_EXPOSURE_OVERHEAD)
      else $error("start overhead not reached after delay");

   AST_TRIG_STARTS: assert property (
      cfg.en && mode_q == emsq_pkg::EMSQ_TRIG && idle && trig_edge
      |=> state == S_DELAY ##1 START_OVERHEAD == 1'b0)
      else $error("trigger edge did not start exposure");

   AST_FALL_IGNORED: assert property (
      mode_q == emsq_pkg::EMSQ_TRIG && idle && !pend && !trig_lvl
      && trig_prev |=> state == S_IDLE)
      else $error("inactive edge started exposure");

   AST_EXPOSE_LEN: assert property (
      mode_q != emsq_pkg::EMSQ_SLAVE && state == S_EXPOSE
      && cnt + 32'h1 >= exp_tgt |=> state == S_END_EXPOSURE_OVERHEAD ##1 END_OVERHEAD)
      else $error("master exposure did not end on count");

   AST_SLAVE_END: assert property (
      mode_q == emsq_pkg::EMSQ_SLAVE && state == S_EXPOSE && !trig_lvl
      |=> state == S_END_EXPOSURE_OVERHEAD)
      else $error("slave deassertion did not end exposure");

   AST_READ_AFTER_END_EXPOSURE_OVERHEAD: assert property (
      state == S_END_EXPOSURE_OVERHEAD && cnt + 32'h1 >= emsq_pkg::END_EXPOSURE_OVERHEAD_CYC
      |=> rd_busy && rd_row == 16'h0 && state == S_IDLE)
      else $error("readout did not follow end overhead");

   AST_FRAME_WRAP: assert property (
      frame_tick && mode_q == emsq_pkg::EMSQ_FREE && cfg.en
      |=> frame_cnt == 32'h0)
      else $error("frame timer did not wrap at frame time");

   AST_MODE_HOLD: assert property (
      !boundary |=> $stable(mode_q))
      else $error("mode changed inside a frame");

   AST_ONE_PENDING: assert property (
      cfg.en && pend && idle |=> !pend && state == S_DELAY)
      else $error("pending trigger not served");
endmodule : emsq_sequencer
`default_nettype wire

// ==== verification/emsq_ctrl_model.sv ====
`default_nettype none
module emsq_ctrl_model (
   input  wire logic clk,
   output var  logic pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial pin = 1'b0;
   // Holds the active level for the whole wanted exposure
   task automatic pulse(input logic act, input int hold);
      @(posedge clk);
      pin <= act;
      repeat (hold) @(posedge clk);
      pin <= ~act;
   endtask : pulse
   task automatic level(input logic v);
      @(posedge clk);
      pin <= v;
   endtask : level
endmodule : emsq_ctrl_model
`default_nettype wire

// ==== verification/tb_exposure_mode_sequencer.sv ====
`default_nettype none
module tb_exposure_mode_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   logic        REF_CLK = 1'b0;
   logic        RST     = 1'b1;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0000_0000;
   logic [31:0] prdata, q;
   logic        pready, pslverr, e, trig, expo, sov, eov, rda, row, fdn;
   logic [2:0]  prv = 3'h0;
   wire logic [2:0] lv = {eov, expo, sov};
   int          failures = 0, samples_checked = 0, cyc = 0, tmo = 0;
   int          rise_t[3], len[3], rises[3], frames = 0, rows = 0;
   int          t0, lat0, r, f, ro, e1, ta, n;
   logic [7:0]  ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
   logic [15:0] rv[6] = '{16'h0000, emsq_pkg::RST_LINE_TIME,
      emsq_pkg::RST_FRAME_LEN, emsq_pkg::RST_COARSE,
      emsq_pkg::RST_FINE, emsq_pkg::RST_OFFSET};

   always #2.5 REF_CLK = ~REF_CLK;

   emsq_sequencer uut (
      .REF_CLK(REF_CLK), .RST(RST), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .TRIG_EXPOSE(trig),
      .EXPOSING(expo), .START_OVERHEAD(sov), .END_OVERHEAD(eov),
      .READOUT_ACTIVE(rda), .ROW_STROBE(row), .FRAME_DONE(fdn)
   );
   emsq_ctrl_model ctrl (.clk(REF_CLK), .pin(trig));

   task automatic chk(input string nm, input logic [31:0] x,
                      input logic [31:0] g);
      samples_checked++;
      if (g !== x) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, x, g);
      end
   endtask : chk

   // Pulse lengths and edge times seen where outputs have settled
   always @(negedge REF_CLK) begin
      cyc++;
      for (int i = 0; i < 3; i++) begin
         if (lv[i] && !prv[i]) begin
            rise_t[i] = cyc;
            rises[i]++;
         end
         if (!lv[i] && prv[i]) len[i] = cyc - rise_t[i];
      end
      prv = lv;
      frames += int'(fdn === 1'b1);
      rows += int'(row === 1'b1);
      if (rda === 1'b1 && (sov | eov) === 1'b1) chk("rd idle", 0, 1);
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : conclude

   always @(posedge REF_CLK) begin
      tmo++;
      if (tmo == 95000) begin
         failures++;
         conclude();
      end
   end

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge REF_CLK);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge REF_CLK);
      penable <= 1'b1;
      // Answer taken at the rising edge where pready is seen high
      do begin
         @(posedge REF_CLK);
         k++;
      end while (pready !== 1'b1 && k < 20);
      q = prdata;
      e = pslverr;
      if (k >= 20) chk("pready", 1, 0);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0000_0000);
   endtask : rd

   // Counter select: 0 start overheads, 1 frames done, 2 rows
   task automatic wait_for(input int k, input int t);
      int m;
      m = 0;
      while ((k == 0 ? rises[0] : k == 1 ? frames : rows) < t
             && m < 30000) begin
         @(negedge REF_CLK);
         m++;
      end
      if (m >= 30000) chk("wait", 1, 0);
   endtask : wait_for

   task automatic trg(input logic act, input int hold);
      @(posedge REF_CLK);
      t0 = cyc;
      r = rises[0];
      f = frames;
      ro = rows;
      ctrl.pulse(act, hold);
   endtask : trg

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask : done

   initial begin
      repeat (3) @(posedge REF_CLK);
      RST <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         rd(ra[i]);
         chk("reset value", {16'h0000, rv[i]}, q);
      end
      wr(emsq_pkg::ADDR_LINE, 32'h0000_5a5a);
      rd(emsq_pkg::ADDR_LINE);
      chk("line rw", 32'h0000_5a5a, q);
      wr(8'h1c, 32'h0000_1234);
      chk("unmapped err", 1, e);
      rd(8'h1c);
      chk("unmapped data", 0, q);
      wr(emsq_pkg::ADDR_CTRL, 32'h0000_0006);
      rd(emsq_pkg::ADDR_STATUS);
      chk("bad mode", 0, 32'(q[5:4]));
      done("registers");
      wr(emsq_pkg::ADDR_LINE, 32'h0000_0002);
      wr(emsq_pkg::ADDR_COARSE, 32'h0000_07d0);
      wr(emsq_pkg::ADDR_FINE, 32'h0000_0003);
      wr(emsq_pkg::ADDR_CTRL, 32'h0000_0003);
      trg(1'b1, 40);
      wait_for(1, f + 1);
      lat0 = rise_t[0] - t0;
      chk("starts", r + 1, rises[0]);
      chk("latency", 1, lat0 >= 4 && lat0 <= 12);
      chk("start_exposure_overhead len", emsq_pkg::START_EXPOSURE_OVERHEAD_CYC, len[0]);
      chk("exposure", 4003, len[1]);
      chk("end_exposure_overhead len", emsq_pkg::END_EXPOSURE_OVERHEAD_CYC, len[2]);
      chk("rows", ro + 'hc10, rows);
      done("trigger master");
      wr(emsq_pkg::ADDR_OFFSET, 32'h0000_0003);
      trg(1'b1, 20);
      wait_for(0, r + 1);
      chk("offset delay", 6, rise_t[0] - t0 - lat0);
      wait_for(2, ro + 'hc10 - 1500);
      trg(1'b1, 20);
      wait_for(1, f + 2);
      chk("pipelined starts", r + 1, rises[0]);
      chk("pipelined rows", ro + 1500 + 'hc10, rows);
      rd(emsq_pkg::ADDR_STATUS);
      chk("images", 3, 32'(q[31:16]));
      done("pipelined");
      wr(emsq_pkg::ADDR_CTRL, 32'h0000_0005);
      trg(1'b1, 2100);
      wait_for(1, f + 1);
      e1 = len[1];
      chk("slave start_exposure_overhead", emsq_pkg::START_EXPOSURE_OVERHEAD_CYC, len[0]);
      trg(1'b1, 2150);
      wait_for(1, f + 1);
      chk("slave step", 50, len[1] - e1);
      done("slave");
      wr(emsq_pkg::ADDR_FRAME, 32'h0000_1500);
      wr(emsq_pkg::ADDR_CTRL, 32'h0000_0001);
      ctrl.level(1'b1);
      r = rises[0];
      wait_for(0, r + 1);
      ta = rise_t[0];
      wait_for(0, r + 2);
      chk("frame time", 'h1500 * 2, rise_t[0] - ta);
      chk("free exposure", 4003, len[1]);
      // Written while a sequence runs, so the old mode must stay
      wr(emsq_pkg::ADDR_CTRL, 32'h0000_000b);
      rd(emsq_pkg::ADDR_STATUS);
      chk("mode held", 0, 32'(q[5:4]));
      n = 0;
      do begin
         repeat (50) @(posedge REF_CLK);
         rd(emsq_pkg::ADDR_STATUS);
         n++;
      end while (q[5:4] !== 2'b01 && n < 400);
      chk("mode applied", 1, 32'(q[5:4]));
      done("free running");
      trg(1'b0, 40);
      wait_for(0, r + 1);
      chk("inverted start", r + 1, rises[0]);
      done("polarity");
      conclude();
   end
endmodule : tb_exposure_mode_sequencer
`default_nettype wire
